// >>> bbm_top.sv
// Bus breakpoint address match with APB register access and interrupt
`timescale 1ns/1ns
// Notes on behaviour
// - Without size masking and with block selection 00 a hit needs address and size to equal the programmed values exactly.
// - Size is compared only with block selection 00, coded 00 long, 01 byte, 10 word, 11 three bytes.
// - With size masking the low offset, access offset and size decide a hit by the overlap table.
// - A hit needs the access to touch the programmed byte, except that offset 1 also hits any access at offsets 2 and 3.
// - Invert match hits outside the block, while direction, size and space checks stay unchanged.
// - Invert match is ignored when block selection is 00.
// - Block selection masks address bits none, 10-0, 12-0 or 14-0.
// - Each set space mask bit suppresses hits in its space; all clear means spaces do not matter.
// - For function codes bit 8 covers 1xxx and bits 7-0 cover codes 0111-0000.
// - For transfer types bit 7 covers acknowledge, bits 6-0 modifiers 110-000, bit 8 unused.
// - No break request is raised for a bus cycle seen while the valid bit is clear.
// - With size masking the size code is excluded and overlap decides.
// - Direction selection 00 reads, 01 writes, 10 both, 11 reserved and never hits.
// - The watch address holds a full 32-bit compare value.
// - Bus source 0 uses the internal bus, 1 the external bus with address bits 1-0 excluded.
module bbm_top (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic INT_CYCLE_VALID,
   input wire logic [31:0] INT_ADDRESS,
   input wire logic [1:0] INT_SIZE_CODE,
   input wire logic INT_WRITE,
   input wire logic [3:0] INT_FUNCTION_CODE,
   input wire logic EXT_CYCLE_VALID,
   input wire logic [31:0] EXT_ADDRESS,
   input wire logic [1:0] EXT_SIZE_CODE,
   input wire logic EXT_WRITE,
   input wire logic EXT_TT_MODE,
   input wire logic [3:0] EXT_FUNCTION_CODE,
   input wire logic [1:0] EXT_TRANSFER_TYPE,
   input wire logic [2:0] EXT_TRANSFER_MODIFIER,
   output logic BREAK_REQUEST_OUT,
   output logic IRQ
);
   // =====================================
   // Overlap table for size-masked matching
   function automatic logic overlap_hit(input logic [1:0] watch_low_offset, input logic [1:0] a,
                                        input logic [1:0] s);
      logic r;
      r = 1'b0;
      case (watch_low_offset)
         2'h0: begin
            r = (a == 2'h0);
         end
         2'h1: begin
            r = (a != 2'h0) || (s == bbm_pkg::SIZE_LONG) || s[1];
         end
         2'h2: begin
            case (a)
               2'h0: begin
                  r = (s == bbm_pkg::SIZE_LONG) || (s == bbm_pkg::SIZE_TRIPLE);
               end
               2'h1: begin
                  r = (s != bbm_pkg::SIZE_BYTE);
               end
               2'h2: begin
                  r = 1'b1;
               end
               default: begin
                  r = 1'b0;
               end
            endcase
         end
         default: begin
            case (a)
               2'h0: begin
                  r = (s == bbm_pkg::SIZE_LONG);
               end
               2'h1: begin
                  r = (s == bbm_pkg::SIZE_LONG) || (s == bbm_pkg::SIZE_TRIPLE);
               end
               2'h2: begin
                  r = (s == bbm_pkg::SIZE_LONG) || s[1];
               end
               default: begin
                  r = 1'b1;
               end
            endcase
         end
      endcase
      return r;
   endfunction

   // =====================================
   // Pin synchronisers for the external bus
   // Valid, address, size, write, mode, code, type and modifier: 1+32+2+1+1+4+2+3 bits
   localparam int EXT_W = 46;
   logic [EXT_W-1:0] ext_s1_reg;
   logic [EXT_W-1:0] ext_s2_reg;
   logic [EXT_W-1:0] ext_s3_reg;
   logic [EXT_W-1:0] ext_held_reg;
   wire logic [EXT_W-1:0] ext_raw;
   wire logic [EXT_W-1:0] ext_next;
   assign ext_raw = {EXT_CYCLE_VALID, EXT_ADDRESS, EXT_SIZE_CODE, EXT_WRITE, EXT_TT_MODE,
                     EXT_FUNCTION_CODE, EXT_TRANSFER_TYPE, EXT_TRANSFER_MODIFIER};
   // Each bit takes a new value only once stages two and three agree
   assign ext_next = (ext_s2_reg & ext_s3_reg) | (~(ext_s2_reg ^ ext_s3_reg) & ext_s2_reg) |
                     ((ext_s2_reg ^ ext_s3_reg) & ext_held_reg);

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ext_s1_reg <= '0;
         ext_s2_reg <= '0;
         ext_s3_reg <= '0;
         ext_held_reg <= '0;
      end else if (CE) begin
         ext_s1_reg <= ext_raw;
         ext_s2_reg <= ext_s1_reg;
         ext_s3_reg <= ext_s2_reg;
         ext_held_reg <= ext_next;
      end
   end

   wire logic e_valid = ext_held_reg[45];
   wire logic [31:0] e_addr = ext_held_reg[44:13];
   wire logic [1:0] e_size = ext_held_reg[12:11];
   wire logic e_write = ext_held_reg[10];
   wire logic e_tt = ext_held_reg[9];
   wire logic [3:0] e_fc = ext_held_reg[8:5];
   wire logic [1:0] e_type = ext_held_reg[4:3];
   wire logic [2:0] e_mod = ext_held_reg[2:0];

   // A synchronised cycle is seen once, on its valid rising edge
   logic e_valid_d_reg;

   // =====================================
   // Registers
   logic [31:0] watch_address_reg;
   logic [31:0] watch_control_reg;
   logic irq_status_reg;
   logic irq_mask_reg;
   logic break_reg;
   logic [31:0] prdata_reg;

   wire logic ctl_valid = watch_control_reg[bbm_pkg::CTL_VALID];
   wire logic [8:0] space_mask_bits = watch_control_reg[bbm_pkg::CTL_SPACE_HI:bbm_pkg::CTL_SPACE_LO];
   wire logic [1:0] block_mask_sel = watch_control_reg[bbm_pkg::CTL_BLOCK_HI:bbm_pkg::CTL_BLOCK_LO];
   wire logic invert_match = watch_control_reg[bbm_pkg::CTL_INVERT];
   wire logic [1:0] access_size_code = watch_control_reg[bbm_pkg::CTL_SIZE_HI:bbm_pkg::CTL_SIZE_LO];
   wire logic size_ignore_sel = watch_control_reg[bbm_pkg::CTL_SIZE_IGNORE];
   wire logic [1:0] direction_sel = watch_control_reg[bbm_pkg::CTL_DIR_HI:bbm_pkg::CTL_DIR_LO];
   wire logic bus_source_sel = watch_control_reg[bbm_pkg::CTL_BUS_SOURCE];

   // =====================================
   // Monitored cycle selection
   wire logic cyc_valid;
   wire logic [31:0] cyc_addr;
   wire logic [1:0] cyc_size;
   wire logic cyc_write;
   wire logic cyc_tt;
   wire logic [3:0] cyc_fc;
   // One evaluation per cycle: internal strobe as given, external on its edge
   assign cyc_valid = bus_source_sel ? (e_valid && !e_valid_d_reg) : INT_CYCLE_VALID;
   assign cyc_addr = bus_source_sel ? e_addr : INT_ADDRESS;
   assign cyc_size = bus_source_sel ? e_size : INT_SIZE_CODE;
   assign cyc_write = bus_source_sel ? e_write : INT_WRITE;
   assign cyc_tt = bus_source_sel ? e_tt : 1'b0;
   assign cyc_fc = bus_source_sel ? e_fc : INT_FUNCTION_CODE;

   // =====================================
   // Match decision
   wire logic [31:0] block_mask;
   wire logic [31:0] cmp_mask;
   wire logic addr_eq;
   wire logic blocked_mode;
   wire logic addr_ok;
   wire logic size_masked;
   wire logic size_ok;
   wire logic dir_ok;
   wire logic space_blocked;
   wire logic hit;

   assign block_mask = (block_mask_sel == bbm_pkg::BLOCK_2K) ? bbm_pkg::MASK_2K :
                       (block_mask_sel == bbm_pkg::BLOCK_8K) ? bbm_pkg::MASK_8K :
                       (block_mask_sel == bbm_pkg::BLOCK_32K) ? bbm_pkg::MASK_32K :
                       bbm_pkg::MASK_ALL;
   // External bus drops the two low bits from the word compare; overlap covers them
   assign size_masked = size_ignore_sel || bus_source_sel;
   assign cmp_mask = (size_masked && block_mask_sel == bbm_pkg::BLOCK_NONE) ?
                     (block_mask & bbm_pkg::MASK_LOW2) : block_mask;
   assign addr_eq = ((cyc_addr ^ watch_address_reg) & cmp_mask) == 32'h0000_0000;
   assign blocked_mode = (block_mask_sel != bbm_pkg::BLOCK_NONE);
   // Inversion applies to the address only, and only with a block selected
   assign addr_ok = (blocked_mode && invert_match) ? !addr_eq : addr_eq;
   // Exact size compare or overlap table, only in unblocked mode
   assign size_ok = blocked_mode ? 1'b1 :
                    size_masked ? overlap_hit(watch_address_reg[1:0], cyc_addr[1:0], cyc_size) :
                    (cyc_size == access_size_code);
   assign dir_ok = (direction_sel == bbm_pkg::DIR_READ) ? !cyc_write :
                   (direction_sel == bbm_pkg::DIR_WRITE) ? cyc_write :
                   (direction_sel == bbm_pkg::DIR_EITHER);
   // Valid bit gates everything
   assign hit = ctl_valid && cyc_valid && addr_ok && size_ok && dir_ok && !space_blocked;

   bbm_space_gate u_space (
      .space_mask_bits(space_mask_bits),
      .tt_mode(cyc_tt),
      .function_code(cyc_fc),
      .transfer_type(e_type),
      .transfer_modifier(e_mod),
      .space_blocked(space_blocked)
   );

   // =====================================
   // APB slave, zero wait states
   wire logic apb_access = PSEL && PENABLE;
   wire logic apb_write = apb_access && PWRITE;
   wire logic apb_read = apb_access && !PWRITE;
   wire logic sel_addr = (PADDR == bbm_pkg::ADDR_WATCH_ADDRESS);
   wire logic sel_ctl = (PADDR == bbm_pkg::ADDR_WATCH_CONTROL);
   wire logic sel_stat = (PADDR == bbm_pkg::ADDR_IRQ_STATUS);
   wire logic sel_mask = (PADDR == bbm_pkg::ADDR_IRQ_MASK);
   wire logic sel_any = sel_addr || sel_ctl || sel_stat || sel_mask;
   wire logic [31:0] read_mux = sel_addr ? watch_address_reg :
                                sel_ctl ? watch_control_reg :
                                sel_stat ? {31'h0, irq_status_reg} :
                                sel_mask ? {31'h0, irq_mask_reg} : 32'h0000_0000;
   // Read clears only what it reported, so a hit after the setup sample is kept; a hit in the same cycle wins
   wire logic irq_status_next = hit ||
                                (irq_status_reg && !(apb_read && sel_stat && prdata_reg[bbm_pkg::IRQ_HIT_BIT]));

   assign PREADY = 1'b1;
   assign PSLVERR = apb_access && !sel_any;
   assign PRDATA = prdata_reg;
   assign BREAK_REQUEST_OUT = break_reg;
   assign IRQ = irq_status_reg && irq_mask_reg;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         watch_address_reg <= 32'h0000_0000;
         watch_control_reg <= bbm_pkg::WATCH_CONTROL_RESET;
         irq_status_reg <= 1'b0;
         irq_mask_reg <= 1'b0;
         break_reg <= 1'b0;
         e_valid_d_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else if (CE) begin
         e_valid_d_reg <= e_valid;
         // Request is one cycle long per monitored cycle
         break_reg <= hit;
         irq_status_reg <= irq_status_next;
         if (apb_write && sel_addr) begin
            watch_address_reg <= PWDATA;
         end
         if (apb_write && sel_ctl) begin
            watch_control_reg <= PWDATA & bbm_pkg::WATCH_CONTROL_WMASK;
         end
         if (apb_write && sel_mask) begin
            irq_mask_reg <= PWDATA[bbm_pkg::IRQ_HIT_BIT];
         end
         if (PSEL && !PENABLE && !PWRITE) begin
            prdata_reg <= read_mux;
         end
      end
   end
endmodule

// >>> bbm_pkg.sv
// Package of constants for the bus breakpoint match block
package bbm_pkg;
   // =====================================
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_WATCH_ADDRESS = 8'h00;
   localparam logic [7:0] ADDR_WATCH_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [31:0] WATCH_CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] WATCH_CONTROL_WMASK = 32'h000F_FFFF;
   // =====================================
   // Control word fields
   localparam int CTL_VALID = 0;
   localparam int CTL_SPACE_LO = 1;
   localparam int CTL_SPACE_HI = 9;
   localparam int CTL_BLOCK_LO = 10;
   localparam int CTL_BLOCK_HI = 11;
   localparam int CTL_INVERT = 12;
   localparam int CTL_SIZE_LO = 13;
   localparam int CTL_SIZE_HI = 14;
   localparam int CTL_SIZE_IGNORE = 15;
   localparam int CTL_DIR_LO = 16;
   localparam int CTL_DIR_HI = 17;
   localparam int CTL_BUS_SOURCE = 18;
   // =====================================
   // Encodings
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_TRIPLE = 2'h3;
   localparam logic [1:0] BLOCK_NONE = 2'h0;
   localparam logic [1:0] BLOCK_2K = 2'h1;
   localparam logic [1:0] BLOCK_8K = 2'h2;
   localparam logic [1:0] BLOCK_32K = 2'h3;
   localparam logic [31:0] MASK_2K = 32'hFFFF_F800;
   localparam logic [31:0] MASK_8K = 32'hFFFF_E000;
   localparam logic [31:0] MASK_32K = 32'hFFFF_8000;
   localparam logic [31:0] MASK_ALL = 32'hFFFF_FFFF;
   localparam logic [31:0] MASK_LOW2 = 32'hFFFF_FFFC;
   localparam logic [1:0] DIR_READ = 2'h0;
   localparam logic [1:0] DIR_WRITE = 2'h1;
   localparam logic [1:0] DIR_EITHER = 2'h2;
   localparam logic [1:0] TT_ACK = 2'h3;
   localparam logic [1:0] TT_NORMAL = 2'h0;
   localparam int SPACE_DMA_BIT = 8;
   localparam int SPACE_ACK_BIT = 7;
   localparam int IRQ_HIT_BIT = 0;
endpackage

// >>> bbm_space_gate.sv
// Address-space qualifier for one monitored bus cycle
`timescale 1ns/1ns
module bbm_space_gate (
   input wire logic [8:0] space_mask_bits,
   input wire logic tt_mode,
   input wire logic [3:0] function_code,
   input wire logic [1:0] transfer_type,
   input wire logic [2:0] transfer_modifier,
   output logic space_blocked
);
   // =====================================
   // Space decode
   wire logic fc_blocked;
   wire logic tt_blocked;
   // Code 1xxx is DMA, lower codes index bits 7..0 directly
   assign fc_blocked = function_code[3] ? space_mask_bits[bbm_pkg::SPACE_DMA_BIT] :
                       space_mask_bits[function_code[2:0]];
   // Acknowledge type uses bit 7, normal type indexes by modifier; bit 8 unused
   assign tt_blocked = (transfer_type == bbm_pkg::TT_ACK) ? space_mask_bits[bbm_pkg::SPACE_ACK_BIT] :
                       (transfer_type == bbm_pkg::TT_NORMAL && transfer_modifier != 3'h7) ?
                       space_mask_bits[transfer_modifier] : 1'b0;
   // All-zero mask never blocks, so codes do not matter then
   assign space_blocked = tt_mode ? tt_blocked : fc_blocked;
endmodule

// >>> bbm_checker.sv
// Concurrent checks on the ports of the breakpoint match block
`timescale 1ns/1ns
module bbm_checker (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic INT_CYCLE_VALID,
   input wire logic [31:0] INT_ADDRESS,
   input wire logic [1:0] INT_SIZE_CODE,
   input wire logic INT_WRITE,
   input wire logic [3:0] INT_FUNCTION_CODE,
   input wire logic BREAK_REQUEST_OUT,
   input wire logic IRQ
);
   // ==========================================
   // Shadow of the programmed registers
   logic [31:0] ctl_reg;
   logic [31:0] adr_reg;
   logic msk_reg;
   wire wr_en = CE && PSEL && PENABLE && PWRITE;
   wire [1:0] blk = ctl_reg[11:10];
   wire [31:0] diff = INT_ADDRESS ^ adr_reg;
   wire [31:0] bmask = blk == 2'h1 ? bbm_pkg::MASK_2K : blk == 2'h2 ? bbm_pkg::MASK_8K : bbm_pkg::MASK_32K;
   wire addr_ok = blk == 2'h0 ? (diff & bbm_pkg::MASK_LOW2) == 32'h0 : ((diff & bmask) == 32'h0) != ctl_reg[12];
   wire exact = diff[1:0] == 2'h0 && INT_SIZE_CODE == ctl_reg[14:13];
   wire space_off = ctl_reg[INT_FUNCTION_CODE[3] ? 9 : 1 + int'(INT_FUNCTION_CODE[2:0])];
   wire dir_ok = ctl_reg[17:16] == 2'h2 || ctl_reg[17:16] == {1'b0, INT_WRITE};
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctl_reg <= 32'h0;
         adr_reg <= 32'h0;
         msk_reg <= 1'b0;
      end else if (wr_en && PADDR == bbm_pkg::ADDR_WATCH_ADDRESS) begin
         adr_reg <= PWDATA;
      end else if (wr_en && PADDR == bbm_pkg::ADDR_WATCH_CONTROL) begin
         ctl_reg <= PWDATA & bbm_pkg::WATCH_CONTROL_WMASK;
      end else if (wr_en && PADDR == bbm_pkg::ADDR_IRQ_MASK) begin
         msk_reg <= PWDATA[0];
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   a_valid_gate: assert property (BREAK_REQUEST_OUT |-> $past(ctl_reg[0]))
      else $error("break without valid");
   a_int_pulse: assert property (BREAK_REQUEST_OUT && !$past(ctl_reg[18]) |-> $past(INT_CYCLE_VALID))
      else $error("break without bus cycle");
   a_dir_filter: assert property (BREAK_REQUEST_OUT && !$past(ctl_reg[18]) |-> $past(dir_ok))
      else $error("break on wrong direction");
   a_space_mask: assert property (BREAK_REQUEST_OUT && !$past(ctl_reg[18]) |-> !$past(space_off))
      else $error("break in masked space");
   a_addr_block: assert property (BREAK_REQUEST_OUT && !$past(ctl_reg[18]) |-> $past(addr_ok))
      else $error("break on address outside rule");
   a_size_exact: assert property (BREAK_REQUEST_OUT && !$past(ctl_reg[18]) && !$past(ctl_reg[15]) &&
      $past(ctl_reg[11:10]) == 2'h0 |-> $past(exact))
      else $error("break without exact size");
   a_irq_follows: assert property (BREAK_REQUEST_OUT && msk_reg |-> IRQ)
      else $error("interrupt missing after hit");
   a_irq_masked: assert property (IRQ |-> msk_reg)
      else $error("interrupt while masked");
   a_apb_ready: assert property (PSEL && PENABLE |-> PREADY)
      else $error("ready missing");
   a_slverr_map: assert property (PSEL && PENABLE |-> PSLVERR == (PADDR > 8'h0C || PADDR[1:0] != 2'h0))
      else $error("error response wrong");
endmodule

// >>> bbm_bus_model.sv
// External bus master that drives cycles for the breakpoint block to watch
`timescale 1ns/1ns
module bbm_bus_model (
   input wire logic clk,
   output logic ext_valid,
   output logic [31:0] ext_addr,
   output logic [1:0] ext_size,
   output logic ext_write,
   output logic ext_tt_mode,
   output logic [3:0] ext_function_code,
   output logic [1:0] ext_transfer_type,
   output logic [2:0] ext_transfer_modifier
);
   initial begin
      ext_valid = 1'b0;
      ext_addr = 32'h0;
      ext_size = 2'h0;
      ext_write = 1'b1;
      ext_tt_mode = 1'b0;
      ext_function_code = 4'h0;
      ext_transfer_type = 2'h0;
      ext_transfer_modifier = 3'h6;
   end
   // Address, type and code pins go to inverted values when idle so stale data never looks valid
   task automatic ext_cycle(input logic [31:0] a, input logic tt, input logic [1:0] typ, input logic [3:0] fc,
                            input int hold);
      @(posedge clk);
      ext_valid <= 1'b1;
      ext_addr <= a;
      ext_tt_mode <= tt;
      ext_transfer_type <= typ;
      ext_function_code <= fc;
      repeat (hold) @(posedge clk);
      ext_valid <= 1'b0;
      ext_addr <= ~a;
      ext_transfer_type <= ~typ;
      ext_function_code <= ~fc;
   endtask
endmodule

// >>> testbench.sv
// Self-checking testbench for the breakpoint match block
`timescale 1ns/1ns
module testbench;
   logic CLK = 1'b0, RESETN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, iv = 1'b0, iw = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, ia = 32'h0, PRDATA, rd, c, w, r;
   logic PREADY, PSLVERR, BREAK_REQUEST_OUT, IRQ, err, ev, ew, et;
   logic [1:0] isz = 2'h0, esz, ett;
   logic [3:0] ifc = 4'h0, efc;
   logic [2:0] etm;
   logic [31:0] ea, seed = 32'h4E3A0DC5;
   logic [31:0] flips[8] = '{32'h0, 32'h0, 32'h1, 32'h2, 32'h3, 32'h800, 32'h4000, 32'h10_0000};
   logic [8:0] e_sm[6] = '{9'h080, 9'h040, 9'h100, 9'h100, 9'h100, 9'h000};
   logic [3:0] e_fc[6] = '{4'h0, 4'h0, 4'h0, 4'h9, 4'h2, 4'h2};
   logic e_hit[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   int bad_count = 0, tests_run = 0, hits;
   bbm_top uut (.CLK(CLK), .RESETN(RESETN), .CE(1'b1), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .INT_CYCLE_VALID(iv),
      .INT_ADDRESS(ia), .INT_SIZE_CODE(isz), .INT_WRITE(iw), .INT_FUNCTION_CODE(ifc), .EXT_CYCLE_VALID(ev),
      .EXT_ADDRESS(ea), .EXT_SIZE_CODE(esz), .EXT_WRITE(ew), .EXT_TT_MODE(et), .EXT_FUNCTION_CODE(efc),
      .EXT_TRANSFER_TYPE(ett), .EXT_TRANSFER_MODIFIER(etm), .BREAK_REQUEST_OUT(BREAK_REQUEST_OUT), .IRQ(IRQ));
   bbm_bus_model bus (.clk(CLK), .ext_valid(ev), .ext_addr(ea), .ext_size(esz), .ext_write(ew), .ext_tt_mode(et),
      .ext_function_code(efc), .ext_transfer_type(ett), .ext_transfer_modifier(etm));
   initial begin
      forever #10 CLK = ~CLK;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic exp_hit(input logic [31:0] c, w, a, input logic [1:0] sz, input logic wr, input logic [3:0] fc);
      logic [31:0] m;
      logic aok, ov;
      int len, lo, b;
      m = c[11:10] == 2'h1 ? bbm_pkg::MASK_2K : c[11:10] == 2'h2 ? bbm_pkg::MASK_8K : bbm_pkg::MASK_32K;
      len = sz == bbm_pkg::SIZE_LONG ? 4 : int'(sz);
      lo = int'(a[1:0]);
      b = int'(w[1:0]);
      ov = (lo <= b && b < lo + len) || (b == 1 && lo >= 2);
      if (c[11:10] == bbm_pkg::BLOCK_NONE)
         aok = a[31:2] == w[31:2] && (c[15] ? ov : a[1:0] == w[1:0] && sz == c[14:13]);
      else
         aok = (((a ^ w) & m) == 32'h0) != c[12];
      return c[0] && aok && !c[1 + (fc[3] ? 8 : int'(fc[2:0]))]
         && (c[17:16] == bbm_pkg::DIR_EITHER || c[17:16] == {1'b0, wr});
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic run_one(input logic [31:0] c, w, a, input logic [1:0] sz, input logic wr, input logic [3:0] fc,
                          input logic m);
      logic e;
      e = exp_hit(c, w, a, sz, wr, fc);
      apb(1'b1, bbm_pkg::ADDR_WATCH_ADDRESS, w);
      apb(1'b1, bbm_pkg::ADDR_WATCH_CONTROL, c);
      apb(1'b1, bbm_pkg::ADDR_IRQ_MASK, {31'h0, m});
      @(posedge CLK);
      iv <= 1'b1;
      ia <= a;
      isz <= sz;
      iw <= wr;
      ifc <= fc;
      @(posedge CLK);
      iv <= 1'b0;
      ia <= ~a;
      @(negedge CLK);
      check(BREAK_REQUEST_OUT, e);
      check(IRQ, e & m);
      apb(1'b0, bbm_pkg::ADDR_IRQ_STATUS, 32'h0);
      check(rd, {31'h0, e});
      @(negedge CLK);
      check(IRQ, 1'b0);
   endtask
   task automatic results();
      if (bad_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (6) @(posedge CLK);
      RESETN <= 1'b1;
      apb(1'b0, bbm_pkg::ADDR_WATCH_CONTROL, 32'h0);
      check(rd, bbm_pkg::WATCH_CONTROL_RESET);
      apb(1'b1, bbm_pkg::ADDR_WATCH_CONTROL, 32'hFFFF_FFFF);
      apb(1'b0, bbm_pkg::ADDR_WATCH_CONTROL, 32'h0);
      check(rd, 32'h000F_FFFF);
      apb(1'b1, 8'h10, 32'h1234_5678);
      check(err, 1'b1);
      apb(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0);
      run_one(32'h0002_4001, 32'h1000_0002, 32'h1000_0000, bbm_pkg::SIZE_LONG, 1'b0, 4'h1, 1'b1);
      run_one(32'h0002_C001, 32'h1000_0002, 32'h1000_0000, bbm_pkg::SIZE_LONG, 1'b0, 4'h1, 1'b1);
      run_one(32'h0002_1401, 32'h1000_0002, 32'h1000_0802, bbm_pkg::SIZE_BYTE, 1'b1, 4'h5, 1'b0);
      repeat (400) begin
         c = rnd();
         c[18] = 1'b0;
         c[9:1] = c[9:1] & rnd();
         c[0] = c[0] | c[25];
         w = rnd();
         r = rnd();
         run_one(c, w, w ^ flips[r[10:8]], r[1:0], r[2], r[6:3], r[7]);
      end
      // Slow and prompt external cycles, address bits 1-0 ignored there
      for (int k = 0; k < 6; k++) begin
         w = 32'h2468_0000 + k;
         apb(1'b1, bbm_pkg::ADDR_WATCH_ADDRESS, w);
         apb(1'b1, bbm_pkg::ADDR_WATCH_CONTROL, {12'h000, 4'h6, 6'h20, e_sm[k], 1'b1});
         hits = 0;
         fork
            bus.ext_cycle(k == 5 ? w ^ 32'h100 : w, k < 3, k == 0 ? 2'h3 : 2'h0, e_fc[k], 5 + k);
            repeat (20) begin
               @(negedge CLK);
               hits += int'(BREAK_REQUEST_OUT);
            end
         join
         check(hits, e_hit[k]);
         apb(1'b0, bbm_pkg::ADDR_IRQ_STATUS, 32'h0);
         check(rd, {31'h0, e_hit[k]});
      end
      results();
   end
   initial begin
      repeat (20000) @(posedge CLK);
      bad_count++;
      results();
   end
endmodule
bind bbm_top bbm_checker chk (.CLK(CLK), .RESETN(RESETN), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .INT_CYCLE_VALID(INT_CYCLE_VALID), .INT_ADDRESS(INT_ADDRESS), .INT_SIZE_CODE(INT_SIZE_CODE),
   .INT_WRITE(INT_WRITE), .INT_FUNCTION_CODE(INT_FUNCTION_CODE), .BREAK_REQUEST_OUT(BREAK_REQUEST_OUT), .IRQ(IRQ));
